// ===== core/eprom_power_ctrl.sv
// Program memory power gating with settle stall after a slow-to-fast clock change
`timescale 1ns/1ns
module eprom_power_ctrl
    import vref_reg_pkg::*;
#(
    parameter int SETTLE_CYCLES = EPROM_SETTLE_CYCLES
) (
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    input  wire logic enable_i,
    input  wire logic clock_fast_i,
    input  wire logic fetch_i,
    output logic      eprom_power_o,
    output logic      fetch_stall_o
);

    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    // Settle counter needs at least one clock
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least 1");
    end

    eprom_power_state_t state;
    eprom_power_state_t next_state;
    logic [CW-1:0]      count;
    logic [CW-1:0]      next_count;
    logic               clock_fast_prev;

    wire fast_rise      = clock_fast_i & ~clock_fast_prev;
    wire start_settle   = enable_i & fast_rise & (state == PWR_RUN);
    wire settle_done    = (state == PWR_SETTLE) & (count == CW'(1));
    wire next_power     = ~enable_i | fetch_i | clock_fast_i | start_settle | (state == PWR_SETTLE);
    wire next_stall     = start_settle | ((state == PWR_SETTLE) & ~settle_done);

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            PWR_RUN: begin
                if (start_settle) begin
                    next_state = PWR_SETTLE;
                    next_count = CW'(SETTLE_CYCLES);
                end
            end
            PWR_SETTLE: begin
                next_count = count - CW'(1);
                if (settle_done) begin
                    next_state = PWR_RUN;
                end
            end
            default: begin
                next_state = PWR_RUN;
                next_count = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state           <= PWR_RUN;
            count           <= '0;
            clock_fast_prev <= 1'b0;
            eprom_power_o   <= 1'b1;
            fetch_stall_o   <= 1'b0;
        end else begin
            state           <= next_state;
            count           <= next_count;
            clock_fast_prev <= clock_fast_i;
            eprom_power_o   <= next_power;
            fetch_stall_o   <= next_stall;
        end
    end

endmodule : eprom_power_ctrl

// ===== core/vref_and_regulator_control.sv
// Voltage reference select and core regulator control registers
//
// Function
// - Without override, source select 0 picks reference pin, 1 picks supply.
// - Override set forces internal regulator as reference, ignoring source select.
// - Temperature sensor enable bit switches the sensor on or off.
// - Reference control bits 7 to 5 read zero, writes ignored.
// - Reference control bits 1 and 0 read zero, writes ignored.
// - Stop configuration 0 keeps regulator active in stop state.
// - Stop configuration 1 shuts regulator down in stop; only pin reset works.
// - Bypass bit 1 turns regulator off, core runs from supply pin.
// - Memory power controller gates program memory between fetches at slow clock when enabled.
// - Slow-to-fast clock change powers memory on, stalls up to 20 clocks.
`timescale 1ns/1ns
module vref_and_regulator_control
    import vref_reg_pkg::*;
#(
    parameter int SETTLE_CYCLES = EPROM_SETTLE_CYCLES
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire sfr_req_t   sfr_req_i,
    input  wire logic       stop_state_i,
    input  wire logic       clock_fast_i,
    input  wire logic       fetch_i,
    output logic [7:0]      read_data_o,
    output ref_source_t     ref_select_o,
    output logic            temp_sensor_on_o,
    output logic            regulator_on_o,
    output logic            regulator_bypass_o,
    output logic            pin_reset_only_o,
    output logic            eprom_power_o,
    output logic            fetch_stall_o
);

    // Output levels that agree with the register reset values
    localparam logic        RESET_OVERRIDE   = REF_SEL_CTRL_RESET[REF_OVERRIDE_BIT];
    localparam logic        RESET_SOURCE     = REF_SEL_CTRL_RESET[REF_SOURCE_BIT];
    localparam logic        RESET_TEMP_ON    = REF_SEL_CTRL_RESET[TEMP_ENABLE_BIT];
    localparam logic        RESET_BYPASS     = CORE_REG_CTRL_RESET[BYPASS_BIT];
    localparam logic        RESET_REG_ON     = ~RESET_BYPASS;
    localparam ref_source_t RESET_REF_SELECT = RESET_OVERRIDE ? REF_FROM_REGULATOR :
                                               RESET_SOURCE   ? REF_FROM_SUPPLY    :
                                                                REF_FROM_PIN;

    // Settle window must be usable by the memory power controller
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
        $error("SETTLE_CYCLES out of range");
    end

    // Field positions must lie inside the byte
    if (REF_OVERRIDE_BIT > 7 || REF_SOURCE_BIT > 7 || TEMP_ENABLE_BIT > 7 ||
        STOP_CONFIG_BIT > 7 || BYPASS_BIT > 7 || MEM_PWR_CTRL_BIT > 7) begin : g_bad_field
        $error("Control field position outside the register");
    end

    // Reference fields must not share a bit
    if (REF_OVERRIDE_BIT == REF_SOURCE_BIT || REF_OVERRIDE_BIT == TEMP_ENABLE_BIT ||
        REF_SOURCE_BIT == TEMP_ENABLE_BIT) begin : g_bad_ref_fields
        $error("Reference fields overlap");
    end

    // Regulator fields must not share a bit
    if (STOP_CONFIG_BIT == BYPASS_BIT || STOP_CONFIG_BIT == MEM_PWR_CTRL_BIT ||
        BYPASS_BIT == MEM_PWR_CTRL_BIT) begin : g_bad_core_fields
        $error("Regulator fields overlap");
    end

    // Writable mask must cover exactly the three reference fields
    if (REF_SEL_WRITABLE_MASK != ((8'h01 << REF_OVERRIDE_BIT) |
                                  (8'h01 << REF_SOURCE_BIT)   |
                                  (8'h01 << TEMP_ENABLE_BIT))) begin : g_bad_mask
        $error("Reference writable mask does not match its fields");
    end

    // Reset value may not set a bit that always reads zero
    if ((REF_SEL_CTRL_RESET & ~REF_SEL_WRITABLE_MASK) != 8'h00) begin : g_bad_reset
        $error("Reference reset value sets an unused bit");
    end

    // Two registers must not share an address
    if (REF_SEL_CTRL_ADDR == CORE_REG_CTRL_ADDR) begin : g_bad_addr
        $error("Register addresses collide");
    end

    // Reset must leave the regulator running; bypass is unsafe on a high supply
    if (RESET_BYPASS != 1'b0) begin : g_bad_core_reset
        $error("Regulator reset value selects bypass");
    end

    logic [7:0] reference_select_control;
    logic [7:0] core_regulator_control;
    logic [7:0] next_ref_ctrl;
    logic [7:0] next_core_ctrl;

    // Address decode
    wire hit_ref  = (sfr_req_i.addr == REF_SEL_CTRL_ADDR);
    wire hit_core = (sfr_req_i.addr == CORE_REG_CTRL_ADDR);
    wire wr_ref   = sfr_req_i.write & hit_ref;
    wire wr_core  = sfr_req_i.write & hit_core;
    wire rd_any   = sfr_req_i.read;

    // unused reference bits never hold a one
    for (genvar b = 0; b < 8; b++) begin : g_reg_bit
        wire ref_bit_src  = wr_ref  ? sfr_req_i.wdata[b] : reference_select_control[b];
        wire core_bit_src = wr_core ? sfr_req_i.wdata[b] : core_regulator_control[b];
        assign next_ref_ctrl[b]  = REF_SEL_WRITABLE_MASK[b] & ref_bit_src;
        assign next_core_ctrl[b] = core_bit_src;
    end

    // Field views of the values the registers take at this edge; memory power enable is the stored value
    wire next_override = next_ref_ctrl[REF_OVERRIDE_BIT];
    wire next_source   = next_ref_ctrl[REF_SOURCE_BIT];
    wire next_temp_on  = next_ref_ctrl[TEMP_ENABLE_BIT];
    wire next_stop_cfg = next_core_ctrl[STOP_CONFIG_BIT];
    wire next_bypass   = next_core_ctrl[BYPASS_BIT];
    wire mem_pwr_en    = core_regulator_control[MEM_PWR_CTRL_BIT];

    wire ref_source_t next_ref_select = next_override ? REF_FROM_REGULATOR :
                                        next_source   ? REF_FROM_SUPPLY    :
                                                        REF_FROM_PIN;

    // regulator shuts down in stop only when so configured
    wire stop_shutdown = stop_state_i & next_stop_cfg;
    wire next_reg_on   = ~next_bypass & ~stop_shutdown;

    // Unmapped addresses read zero; a read beside a write sees the old value
    wire [7:0] next_read_data = hit_ref  ? reference_select_control :
                                hit_core ? core_regulator_control   :
                                           8'h00;
    wire [7:0] next_read_hold = rd_any ? next_read_data : read_data_o;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reference_select_control <= REF_SEL_CTRL_RESET;
        end else begin
            reference_select_control <= next_ref_ctrl;
        end
    end

    // Reserved regulator bits are stored as written
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            core_regulator_control <= CORE_REG_CTRL_RESET;
        end else begin
            core_regulator_control <= next_core_ctrl;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            read_data_o <= 8'h00;
        end else begin
            read_data_o <= next_read_hold;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ref_select_o <= RESET_REF_SELECT;
        end else begin
            ref_select_o <= next_ref_select;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            temp_sensor_on_o <= RESET_TEMP_ON;
        end else begin
            temp_sensor_on_o <= next_temp_on;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            regulator_on_o <= RESET_REG_ON;
        end else begin
            regulator_on_o <= next_reg_on;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            regulator_bypass_o <= RESET_BYPASS;
        end else begin
            regulator_bypass_o <= next_bypass;
        end
    end

    // only pin reset or power cycle wakes
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pin_reset_only_o <= 1'b0;
        end else begin
            pin_reset_only_o <= stop_shutdown;
        end
    end

    eprom_power_ctrl #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_eprom_power (
        .clk_sys_i     (clk_sys_i),
        .reset_i       (reset_i),
        .enable_i      (mem_pwr_en),
        .clock_fast_i  (clock_fast_i),
        .fetch_i       (fetch_i),
        .eprom_power_o (eprom_power_o),
        .fetch_stall_o (fetch_stall_o)
    );

endmodule : vref_and_regulator_control

// ===== core/vref_reg_pkg.sv
// Constants and types shared by the reference and regulator control block
package vref_reg_pkg;

    // Register addresses on the internal register bus
    localparam logic [7:0] CORE_REG_CTRL_ADDR  = 8'hC7;
    localparam logic [7:0] REF_SEL_CTRL_ADDR   = 8'hD1;

    // Reset values
    localparam logic [7:0] CORE_REG_CTRL_RESET = 8'h00;
    localparam logic [7:0] REF_SEL_CTRL_RESET  = 8'h00;

    // Reference select control fields
    localparam int REF_OVERRIDE_BIT = 4;
    localparam int REF_SOURCE_BIT   = 3;
    localparam int TEMP_ENABLE_BIT  = 2;
    localparam logic [7:0] REF_SEL_WRITABLE_MASK = 8'h1C;

    // Core regulator control fields
    localparam int STOP_CONFIG_BIT  = 7;
    localparam int BYPASS_BIT       = 6;
    localparam int MEM_PWR_CTRL_BIT = 0;

    // Clocks skipped while the program memory supply settles
    localparam int EPROM_SETTLE_CYCLES = 20;

    typedef enum logic [1:0] {
        REF_FROM_PIN       = 2'b00,
        REF_FROM_SUPPLY    = 2'b01,
        REF_FROM_REGULATOR = 2'b10
    } ref_source_t;

    typedef enum logic [0:0] {
        PWR_RUN    = 1'b0,
        PWR_SETTLE = 1'b1
    } eprom_power_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } sfr_req_t;

endpackage : vref_reg_pkg

// ===== testbench/vref_and_regulator_control_assertions.sv
// Concurrent checks on the reference and regulator control ports
`timescale 1ns/1ns
module vref_and_regulator_control_checker
    import vref_reg_pkg::*;
#(
    parameter int SETTLE_CYCLES = EPROM_SETTLE_CYCLES
) (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire sfr_req_t    sfr_req_i,
    input wire logic        stop_state_i,
    input wire logic        clock_fast_i,
    input wire logic        fetch_i,
    input wire logic [7:0]  read_data_o,
    input wire ref_source_t ref_select_o,
    input wire logic        temp_sensor_on_o,
    input wire logic        regulator_on_o,
    input wire logic        regulator_bypass_o,
    input wire logic        pin_reset_only_o,
    input wire logic        eprom_power_o,
    input wire logic        fetch_stall_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire ref_wr = sfr_req_i.write && sfr_req_i.addr == REF_SEL_CTRL_ADDR;
    wire reg_wr = sfr_req_i.write && sfr_req_i.addr == CORE_REG_CTRL_ADDR;
    wire ref_rd = sfr_req_i.read && sfr_req_i.addr == REF_SEL_CTRL_ADDR;
    ref_supply_a: assert property (ref_wr && sfr_req_i.wdata[4:3] == 2'h1 |=>
        ref_select_o == REF_FROM_SUPPLY) else $error("supply select wrong");
    ref_override_a: assert property (ref_wr && sfr_req_i.wdata[4] |=>
        ref_select_o == REF_FROM_REGULATOR) else $error("override ignored");
    temp_enable_a: assert property (ref_wr |=>
        temp_sensor_on_o == $past(sfr_req_i.wdata[2])) else $error("sensor enable wrong");
    ref_unused_a: assert property (ref_rd |=> read_data_o[7:5] == 3'h0 &&
        read_data_o[1:0] == 2'h0) else $error("unused bits not zero");
    stop_active_a: assert property (reg_wr && sfr_req_i.wdata[7:6] == 2'h0 |=>
        regulator_on_o) else $error("regulator off unexpectedly");
    stop_shut_a: assert property (pin_reset_only_o |->
        $past(stop_state_i) && !regulator_on_o) else $error("stop shutdown wrong");
    bypass_off_a: assert property (regulator_bypass_o |-> !regulator_on_o)
        else $error("regulator on in bypass");
    bypass_wr_a: assert property (reg_wr |=>
        regulator_bypass_o == $past(sfr_req_i.wdata[6])) else $error("bypass not written");
    fetch_power_a: assert property ($past(fetch_i) |-> eprom_power_o)
        else $error("memory off during fetch");
    settle_power_a: assert property (fetch_stall_o |-> eprom_power_o)
        else $error("memory off while settling");
    cover property (fetch_stall_o);
    cover property (pin_reset_only_o);
    cover property (ref_select_o == REF_FROM_REGULATOR);
endmodule : vref_and_regulator_control_checker

bind vref_and_regulator_control vref_and_regulator_control_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (
    .clk_sys_i, .reset_i, .sfr_req_i, .stop_state_i, .clock_fast_i, .fetch_i, .read_data_o, .ref_select_o,
    .temp_sensor_on_o, .regulator_on_o, .regulator_bypass_o, .pin_reset_only_o, .eprom_power_o, .fetch_stall_o);

// ===== testbench/vref_and_regulator_control_tb.sv
// Self-checking bench for the reference and regulator control block
`timescale 1ns/1ns
module vref_and_regulator_control_tb
    import vref_reg_pkg::*;
();
    logic        clk_sys_i = 0, reset_i = 1, stop_state_i = 0, clock_fast_i = 0, fetch_i = 0;
    sfr_req_t    sfr_req_i = '0;
    logic [7:0]  read_data_o;
    ref_source_t ref_select_o;
    logic        temp_sensor_on_o, regulator_on_o, regulator_bypass_o, pin_reset_only_o, eprom_power_o, fetch_stall_o;
    int          n_fail = 0, n_compared = 0, k;
    localparam int SETTLE = 3;
    vref_and_regulator_control #(.SETTLE_CYCLES(SETTLE)) i_dut (
        .clk_sys_i, .reset_i, .sfr_req_i, .stop_state_i, .clock_fast_i, .fetch_i, .read_data_o, .ref_select_o,
        .temp_sensor_on_o, .regulator_on_o, .regulator_bypass_o, .pin_reset_only_o, .eprom_power_o, .fetch_stall_o);
    initial forever #50 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle strobe, then one more cycle for the answer
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        sfr_req_i <= '{a, d, w, !w};
        @(negedge clk_sys_i);
        sfr_req_i <= '0;
        @(negedge clk_sys_i);
    endtask : acc
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(negedge clk_sys_i);
        reset_i <= 0;
        @(negedge clk_sys_i);
        acc(CORE_REG_CTRL_ADDR, 8'h00, 0);
        chk(read_data_o, CORE_REG_CTRL_RESET);
        chk({6'h00, regulator_on_o, eprom_power_o}, 8'h03);
        acc(REF_SEL_CTRL_ADDR, 8'hFF, 1);
        acc(REF_SEL_CTRL_ADDR, 8'h00, 0);
        chk(read_data_o, 8'h1C);
        chk({ref_select_o, 5'h00, temp_sensor_on_o}, 8'h81);
        acc(8'h80, 8'hFF, 1);
        acc(8'h80, 8'h00, 0);
        chk(read_data_o, 8'h00);
        for (k = 0; k < 4; k++) begin
            acc(REF_SEL_CTRL_ADDR, 8'(k * 8), 1);
            chk({ref_select_o, 5'h00, temp_sensor_on_o}, k > 1 ? 8'h80 : 8'(k * 64));
        end
        acc(CORE_REG_CTRL_ADDR, 8'h80, 1);
        stop_state_i <= 1;
        repeat (2) @(negedge clk_sys_i);
        chk({regulator_on_o, regulator_bypass_o, pin_reset_only_o}, 8'h01);
        acc(CORE_REG_CTRL_ADDR, 8'h40, 1);
        chk({regulator_on_o, regulator_bypass_o, pin_reset_only_o}, 8'h02);
        acc(CORE_REG_CTRL_ADDR, 8'h00, 1);
        chk({regulator_on_o, regulator_bypass_o, pin_reset_only_o}, 8'h04);
        stop_state_i <= 0;
        acc(CORE_REG_CTRL_ADDR, 8'h01, 1);
        @(negedge clk_sys_i);
        chk(8'(eprom_power_o), 8'h00);
        fetch_i <= 1;
        @(negedge clk_sys_i);
        chk(8'(eprom_power_o), 8'h01);
        fetch_i <= 0;
        clock_fast_i <= 1;
        k = 0;
        repeat (8) begin
            @(negedge clk_sys_i);
            k += fetch_stall_o;
        end
        chk(8'(k), 8'(SETTLE));
        chk(8'(eprom_power_o), 8'h01);
        acc(CORE_REG_CTRL_ADDR, 8'h00, 0);
        chk(read_data_o, 8'h01);
        stop_test();
    end
endmodule : vref_and_regulator_control_tb
